/* tmr2_defs.svh */
// Constants for the up/down auto-reload timer: offsets, fields, reset values, timing
`ifndef TMR2_DEFS_SVH
`define TMR2_DEFS_SVH
`define TMR_ADDR_W        4
`define TMR_OFS_CTRL      4'h0
`define TMR_OFS_MODE      4'h1
`define TMR_OFS_CNT_LO    4'h2
`define TMR_OFS_CNT_HI    4'h3
`define TMR_OFS_RLD_LO    4'h4
`define TMR_OFS_RLD_HI    4'h5
`define TMR_OFS_IRQ_STAT  4'h6
`define TMR_OFS_IRQ_MASK  4'h7
`define TMR_CTRL_OVF      7
`define TMR_CTRL_EXT      6
`define TMR_CTRL_RXCLK    5
`define TMR_CTRL_TXCLK    4
`define TMR_CTRL_EXTEN    3
`define TMR_CTRL_RUN      2
`define TMR_CTRL_CT       1
`define TMR_CTRL_CPRL     0
`define TMR_MODE_DOWN_COUNT_ENABLE     0
`define TMR_IRQ_OVF       0
`define TMR_IRQ_EXT       1
`define TMR_BYTE_RST      8'h00
`define TMR_BYTE_MAX      8'hFF
`define TMR_CNT_MAX       16'hFFFF
`define TMR_PRESCALE      4'hC
`define TMR_PRESCALE_LAST 4'hB
`define TMR_PRESCALE_RST  4'h0
`endif

/* tmr2_pkg.sv */
// Types for the up/down auto-reload timer
package tmr2_pkg;
    typedef enum logic [1:0] {TMR2_CAPTURE, TMR2_RELOAD, TMR2_BAUD} tmr2_mode_e;
    typedef logic [7:0] tmr2_byte_t;
endpackage

/* tmr2_timer.sv */
// 16-bit up/down auto-reload timer/counter with register port and interrupt
// Summary of operation
// - Count is low byte cascaded into high byte
// - Select clock divided by twelve or pin
// - Count advances only while run bit set
// - Three modes chosen by clock and capture selects
// - Down enable clear: classic up-only reload
// - Down enable set: direction pin picks direction in reload mode only
// - Up overflow past FFFFh sets flag, interrupts
// - Up overflow loads reload pair into count, except in capture mode
// - Down underflow when count equals reload pair
// - Underflow sets flag and loads FFFFh
// - Up/down mode toggles external flag, no interrupt
// - External flag readable as seventeenth bit
// - Overflow flag set only without serial clocks; software clears
// - Counter mode counts falling pin edges
// - Serial clock selects force auto-reload
// - Direction pin fall captures or reloads when enabled, in capture or reload mode only, not baud or up/down
`include "tmr2_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tmr2_timer
    import tmr2_pkg::*;
(
    input  wire logic                  i_clock,
    input  wire logic                  i_srst,
    input  wire logic [`TMR_ADDR_W-1:0] i_addr,
    input  wire logic [7:0]            i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    input  wire logic                  i_count_input_pin,
    input  wire logic                  i_direction_pin,
    output logic      [7:0]            o_rdata,
    output logic                       o_irq,
    output logic                       o_tx_clock_tick,
    output logic                       o_rx_clock_tick
);
    logic [7:0]  ctrl_ff;
    logic        down_count_enable_ff;
    tmr2_byte_t  count_low_byte_ff;
    tmr2_byte_t  count_high_byte_ff;
    tmr2_byte_t  reload_low_byte_ff;
    tmr2_byte_t  reload_high_byte_ff;
    logic [1:0]  irq_stat_ff;
    logic [1:0]  irq_mask_ff;
    logic [3:0]  prescale_ff;
    logic [2:0]  cnt_pin_sync_ff;
    logic [2:0]  dir_pin_sync_ff;
    logic [7:0]  rdata_ff;
    logic        ovf_tick_ff;

    wire logic ctrl_wr   = i_wr && (i_addr == `TMR_OFS_CTRL);
    wire logic run_control            = ctrl_ff[`TMR_CTRL_RUN];
    wire logic counter_timer_select   = ctrl_ff[`TMR_CTRL_CT];
    wire logic capture_reload_select  = ctrl_ff[`TMR_CTRL_CPRL];
    wire logic external_enable        = ctrl_ff[`TMR_CTRL_EXTEN];
    wire logic tx_clock_select        = ctrl_ff[`TMR_CTRL_TXCLK];
    wire logic rx_clock_select        = ctrl_ff[`TMR_CTRL_RXCLK];
    wire logic serial_clk = tx_clock_select || rx_clock_select;

    // Mode decode
    tmr2_mode_e mode;
    always_comb
    begin
        if (serial_clk)
            mode = TMR2_BAUD;
        else if (capture_reload_select)
            mode = TMR2_CAPTURE;
        else
            mode = TMR2_RELOAD;
    end

    // Pin synchronisers, stage 0 feeds only stage 1
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            cnt_pin_sync_ff <= 3'h7;
            dir_pin_sync_ff <= 3'h7;
        end
        else
        begin
            cnt_pin_sync_ff <= {cnt_pin_sync_ff[1:0], i_count_input_pin};
            dir_pin_sync_ff <= {dir_pin_sync_ff[1:0], i_direction_pin};
        end
    end
    wire logic cnt_fall = cnt_pin_sync_ff[2] && !cnt_pin_sync_ff[1];
    wire logic dir_fall = dir_pin_sync_ff[2] && !dir_pin_sync_ff[1];
    wire logic dir_level = dir_pin_sync_ff[1];

    // Divide-by-twelve prescaler for timer operation
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            prescale_ff <= `TMR_PRESCALE_RST;
        else if (prescale_ff == `TMR_PRESCALE_LAST)
            prescale_ff <= `TMR_PRESCALE_RST;
        else
            prescale_ff <= prescale_ff + 4'h1;
    end
    wire logic div_tick = (prescale_ff == `TMR_PRESCALE_LAST);

    wire logic tick = run_control && (counter_timer_select ? cnt_fall : div_tick);

    // Direction: up unless down enable in reload mode and pin low
    wire logic updown  = down_count_enable_ff && (mode == TMR2_RELOAD);
    wire logic count_dn = updown && !dir_level;

    wire logic [15:0] count  = {count_high_byte_ff, count_low_byte_ff};
    wire logic [15:0] reload = {reload_high_byte_ff, reload_low_byte_ff};
    wire logic ovf_up = tick && !count_dn && (count == `TMR_CNT_MAX);
    wire logic unf_dn = tick && count_dn && (count == reload);
    wire logic wrap   = ovf_up || unf_dn;
    // External pin event only in classic modes, not baud or up/down
    wire logic ext_evt = external_enable && dir_fall && !serial_clk && !updown;
    wire logic ext_reload  = ext_evt && (mode == TMR2_RELOAD);
    wire logic ext_capture = ext_evt && (mode == TMR2_CAPTURE);
    wire logic ovf_reload = ovf_up && (mode != TMR2_CAPTURE);

    // Count bytes with cascade and same-cycle reload
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            count_low_byte_ff  <= `TMR_BYTE_RST;
            count_high_byte_ff <= `TMR_BYTE_RST;
        end
        else if (ovf_reload || ext_reload)
        begin
            count_low_byte_ff  <= reload_low_byte_ff;
            count_high_byte_ff <= reload_high_byte_ff;
        end
        else if (unf_dn)
        begin
            count_low_byte_ff  <= `TMR_BYTE_MAX;
            count_high_byte_ff <= `TMR_BYTE_MAX;
        end
        else if (tick)
        begin
            if (count_dn)
            begin
                count_low_byte_ff <= count_low_byte_ff - 8'h01;
                if (count_low_byte_ff == `TMR_BYTE_RST)
                    count_high_byte_ff <= count_high_byte_ff - 8'h01;
            end
            else
            begin
                count_low_byte_ff <= count_low_byte_ff + 8'h01;
                if (count_low_byte_ff == `TMR_BYTE_MAX)
                    count_high_byte_ff <= count_high_byte_ff + 8'h01;
            end
        end
        else if (i_wr && i_addr == `TMR_OFS_CNT_LO)
            count_low_byte_ff <= i_wdata;
        else if (i_wr && i_addr == `TMR_OFS_CNT_HI)
            count_high_byte_ff <= i_wdata;
    end

    // Reload pair: software writes, or capture from the pin
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            reload_low_byte_ff  <= `TMR_BYTE_RST;
            reload_high_byte_ff <= `TMR_BYTE_RST;
        end
        else if (ext_capture)
        begin
            reload_low_byte_ff  <= count_low_byte_ff;
            reload_high_byte_ff <= count_high_byte_ff;
        end
        else if (i_wr && i_addr == `TMR_OFS_RLD_LO)
            reload_low_byte_ff <= i_wdata;
        else if (i_wr && i_addr == `TMR_OFS_RLD_HI)
            reload_high_byte_ff <= i_wdata;
    end

    // Control register; hardware sets of flags win over software writes
    wire logic set_ovf = (ovf_up || unf_dn) && !serial_clk;
    logic nxt_ext;
    always_comb
    begin
        nxt_ext = ctrl_wr ? i_wdata[`TMR_CTRL_EXT] : ctrl_ff[`TMR_CTRL_EXT];
        if (updown && wrap)
            nxt_ext = !ctrl_ff[`TMR_CTRL_EXT];
        else if (ext_evt)
            nxt_ext = 1'b1;
    end
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            ctrl_ff <= `TMR_BYTE_RST;
        else
        begin
            if (ctrl_wr)
                ctrl_ff <= i_wdata;
            if (set_ovf)
                ctrl_ff[`TMR_CTRL_OVF] <= 1'b1;
            ctrl_ff[`TMR_CTRL_EXT] <= nxt_ext;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            down_count_enable_ff <= 1'b0;
        else if (i_wr && i_addr == `TMR_OFS_MODE)
            down_count_enable_ff <= i_wdata[`TMR_MODE_DOWN_COUNT_ENABLE];
    end

    // Sticky interrupt status, write one to clear, set wins
    wire logic ovf_evt = set_ovf;
    wire logic ext_irq_evt = ext_evt;                 // toggle never raises this
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            irq_stat_ff <= 2'h0;
        else
        begin
            irq_stat_ff <= (irq_stat_ff
                & ~((i_wr && i_addr == `TMR_OFS_IRQ_STAT) ? i_wdata[1:0] : 2'h0))
                | {ext_irq_evt, ovf_evt};
        end
    end
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            irq_mask_ff <= 2'h0;
        else if (i_wr && i_addr == `TMR_OFS_IRQ_MASK)
            irq_mask_ff <= i_wdata[1:0];
    end
    assign o_irq = |(irq_stat_ff & irq_mask_ff);

    // Baud-rate tick out on every overflow in serial-clock mode
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            ovf_tick_ff <= 1'b0;
        else
            ovf_tick_ff <= ovf_up && serial_clk;
    end
    assign o_tx_clock_tick = ovf_tick_ff && tx_clock_select;
    assign o_rx_clock_tick = ovf_tick_ff && rx_clock_select;

    // Read data one cycle after the strobe
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            rdata_ff <= `TMR_BYTE_RST;
        else if (i_rd)
        begin
            unique case (i_addr)
                `TMR_OFS_CTRL:     rdata_ff <= ctrl_ff;
                `TMR_OFS_MODE:     rdata_ff <= {7'h00, down_count_enable_ff};
                `TMR_OFS_CNT_LO:   rdata_ff <= count_low_byte_ff;
                `TMR_OFS_CNT_HI:   rdata_ff <= count_high_byte_ff;
                `TMR_OFS_RLD_LO:   rdata_ff <= reload_low_byte_ff;
                `TMR_OFS_RLD_HI:   rdata_ff <= reload_high_byte_ff;
                `TMR_OFS_IRQ_STAT: rdata_ff <= {6'h00, irq_stat_ff};
                `TMR_OFS_IRQ_MASK: rdata_ff <= {6'h00, irq_mask_ff};
                default:           rdata_ff <= `TMR_BYTE_RST;
            endcase
        end
        else
            rdata_ff <= `TMR_BYTE_RST;
    end
    assign o_rdata = rdata_ff;

    // Assertions
    property p_up_reload;
        @(posedge i_clock) disable iff (i_srst)
        (ovf_up && mode == TMR2_RELOAD) |=> (count == $past(reload));
    endproperty
    a_up_reload: assert property (p_up_reload) else $error("up overflow did not reload");

    property p_dn_unf;
        @(posedge i_clock) disable iff (i_srst)
        unf_dn |=> (count == `TMR_CNT_MAX) && ctrl_ff[`TMR_CTRL_OVF];
    endproperty
    a_dn_unf: assert property (p_dn_unf) else $error("underflow did not load max");

    property p_hold;
        @(posedge i_clock) disable iff (i_srst)
        (!run_control && !i_wr && !ext_evt) |=> (count == $past(count));
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while stopped");

    property p_ovf_flag;
        @(posedge i_clock) disable iff (i_srst)
        (ovf_up && !serial_clk) |=> ctrl_ff[`TMR_CTRL_OVF] && irq_stat_ff[`TMR_IRQ_OVF];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

    property p_no_ovf_serial;
        @(posedge i_clock) disable iff (i_srst)
        (serial_clk && !ctrl_ff[`TMR_CTRL_OVF] && !ctrl_wr) |=> !ctrl_ff[`TMR_CTRL_OVF];
    endproperty
    a_no_ovf_serial: assert property (p_no_ovf_serial) else $error("flag set in serial mode");

    property p_toggle;
        @(posedge i_clock) disable iff (i_srst)
        (updown && wrap) |=> (ctrl_ff[`TMR_CTRL_EXT] != $past(ctrl_ff[`TMR_CTRL_EXT]))
            && (!irq_stat_ff[`TMR_IRQ_EXT] || $past(irq_stat_ff[`TMR_IRQ_EXT]));
    endproperty
    a_toggle: assert property (p_toggle) else $error("external flag did not toggle");

    property p_carry;
        @(posedge i_clock) disable iff (i_srst)
        (tick && !count_dn && !wrap && !ext_reload && count_low_byte_ff == `TMR_BYTE_MAX)
            |=> count_high_byte_ff == $past(count_high_byte_ff) + 8'h01
                && count_low_byte_ff == `TMR_BYTE_RST;
    endproperty
    a_carry: assert property (p_carry) else $error("no carry into high byte");

    property p_prescale;
        @(posedge i_clock) disable iff (i_srst)
        div_tick |=> !div_tick [*8] ##1 !div_tick [*3] ##1 div_tick;
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescaler not twelve");

    property p_dir_down;
        @(posedge i_clock) disable iff (i_srst)
        (tick && updown && !dir_level && !unf_dn) |=> count == $past(count) - 16'h0001;
    endproperty
    a_dir_down: assert property (p_dir_down) else $error("pin low did not count down");

    property p_pin_count;
        @(posedge i_clock) disable iff (i_srst)
        (run_control && counter_timer_select && cnt_fall && !count_dn && !wrap && !ext_reload)
            |=> count == $past(count) + 16'h0001;
    endproperty
    a_pin_count: assert property (p_pin_count) else $error("pin edge not counted");

    property p_baud_reload;
        @(posedge i_clock) disable iff (i_srst)
        (ovf_up && serial_clk) |=> count == $past(reload);
    endproperty
    a_baud_reload: assert property (p_baud_reload) else $error("serial mode did not reload");

    property p_ext_capture;
        @(posedge i_clock) disable iff (i_srst)
        ext_capture |=> reload == $past(count);
    endproperty
    a_ext_capture: assert property (p_ext_capture) else $error("pin fall did not capture");
endmodule // tmr2_timer
`default_nettype wire

/* tmr2_pins.sv */
// Behavioural model of the external count and direction pins
`timescale 1ns/1ps
`default_nettype none
module tmr2_pins
(
    input  wire logic i_clock,
    input  wire logic i_srst,
    input  wire logic i_fall,
    input  wire logic i_dir_up,
    output logic      o_count_input_pin,
    output logic      o_direction_pin
);
    logic [2:0] low_ff;
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            low_ff <= 3'h0;
        else if (i_fall)
            low_ff <= 3'h4;
        else if (low_ff != 3'h0)
            low_ff <= low_ff - 3'h1;
    end
    // Idle high; each request gives one four-cycle low pulse
    assign o_count_input_pin = (low_ff == 3'h0);
    // High asks for up, low for down; a fall is an external event
    assign o_direction_pin = i_dir_up;
endmodule // tmr2_pins
`default_nettype wire

/* test_tmr2_timer.sv */
// Self-checking bench for the up/down auto-reload timer
`include "tmr2_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_tmr2_timer
    import tmr2_pkg::*;
;
    typedef struct packed {logic [3:0] a; tmr2_byte_t d; tmr2_byte_t e;} tmr2_row_s;
    logic       clock;
    logic       srst;
    logic       wr;
    logic       rd;
    logic       fall;
    logic       dir_up;
    logic       irq;
    logic       cnt_pin;
    logic       dir_pin;
    logic       tx_tick;
    logic       rx_tick;
    logic [3:0] addr;
    tmr2_byte_t wdata;
    tmr2_byte_t rdata;
    tmr2_byte_t tx_ticks;
    tmr2_byte_t rx_ticks;
    int         errors;
    int         num_checks;
    tmr2_row_s  rows [9] = '{'{4'h4, 8'hA5, 8'hA5}, '{4'h5, 8'h5A, 8'h5A},
        '{4'h7, 8'h03, 8'h03}, '{4'h1, 8'h01, 8'h01}, '{4'h1, 8'h00, 8'h00},
        '{4'h2, 8'h3C, 8'h3C}, '{4'h3, 8'hC3, 8'hC3}, '{4'h9, 8'hFF, 8'h00},
        '{4'h7, 8'h00, 8'h00}};

    tmr2_timer tmr2_timer_inst (.i_clock(clock), .i_srst(srst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_count_input_pin(cnt_pin),
        .i_direction_pin(dir_pin), .o_rdata(rdata), .o_irq(irq),
        .o_tx_clock_tick(tx_tick), .o_rx_clock_tick(rx_tick));
    tmr2_pins tmr2_pins_inst (.i_clock(clock), .i_srst(srst), .i_fall(fall),
        .i_dir_up(dir_up), .o_count_input_pin(cnt_pin), .o_direction_pin(dir_pin));

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Counts baud tick pulses, one per cycle they stand
    always @(posedge clock)
    begin
        if (srst)
        begin
            tx_ticks <= 8'h00;
            rx_ticks <= 8'h00;
        end
        else
        begin
            if (tx_tick === 1'b1)
                tx_ticks <= tx_ticks + 8'h01;
            if (rx_tick === 1'b1)
                rx_ticks <= rx_ticks + 8'h01;
        end
    end

    task automatic check(input tmr2_byte_t got, input tmr2_byte_t exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input tmr2_byte_t d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic chk_rd(input logic [3:0] a, input tmr2_byte_t e, input string what);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 check(rdata, e, what);
    endtask

    // One rise and fall of the direction pin, long enough to pass the synchroniser
    task automatic pin_fall();
        @(posedge clock);
        dir_up <= 1'b1;
        repeat (6) @(posedge clock);
        dir_up <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #40000;
        errors++;
        report_and_stop();
    end

    initial
    begin
        srst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        fall = 1'b0;
        dir_up = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
        errors = 0;
        num_checks = 0;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        foreach (rows[i])
        begin
            wr_reg(rows[i].a, rows[i].d);
            chk_rd(rows[i].a, rows[i].e, "row");
        end
        $display("test rows done");
        // Reset with the timer stopped clears every register; unmapped places read zero
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        for (int a = 0; a < 16; a++)
            chk_rd(a[3:0], 8'h00, "reset");
        $display("test reset done");
        // 120 running cycles hold exactly ten prescaler ticks
        wr_reg(`TMR_OFS_CTRL, 8'h04);
        repeat (118) @(posedge clock);
        wr_reg(`TMR_OFS_CTRL, 8'h00);
        chk_rd(`TMR_OFS_CNT_LO, 8'h0A, "div12");
        repeat (30) @(posedge clock);
        chk_rd(`TMR_OFS_CNT_LO, 8'h0A, "hold");
        $display("test prescale done");
        wr_reg(`TMR_OFS_RLD_LO, 8'hFE);
        wr_reg(`TMR_OFS_RLD_HI, 8'h12);
        wr_reg(`TMR_OFS_CNT_LO, 8'hFE);
        wr_reg(`TMR_OFS_CNT_HI, 8'hFF);
        wr_reg(`TMR_OFS_IRQ_MASK, 8'h01);
        wr_reg(`TMR_OFS_CTRL, 8'h04);
        repeat (28) @(posedge clock);
        chk_rd(`TMR_OFS_CTRL, 8'h84, "ovf flag");
        check({7'h00, irq}, 8'h01, "irq");
        wr_reg(`TMR_OFS_CTRL, 8'h00);
        chk_rd(`TMR_OFS_CNT_HI, 8'h12, "reload");
        chk_rd(`TMR_OFS_CTRL, 8'h00, "sw clear");
        wr_reg(`TMR_OFS_IRQ_MASK, 8'h00);
        #1 check({7'h00, irq}, 8'h00, "masked");
        wr_reg(`TMR_OFS_IRQ_STAT, 8'h01);
        wr_reg(`TMR_OFS_IRQ_MASK, 8'h01);
        #1 check({7'h00, irq}, 8'h00, "cleared");
        $display("test overflow done");
        // Counter mode with the direction pin low still counts up
        wr_reg(`TMR_OFS_CNT_LO, 8'h00);
        dir_up <= 1'b0;
        wr_reg(`TMR_OFS_CNT_HI, 8'h00);
        wr_reg(`TMR_OFS_CTRL, 8'h06);
        repeat (3)
        begin
            @(posedge clock);
            fall <= 1'b1;
            @(posedge clock);
            fall <= 1'b0;
            repeat (10) @(posedge clock);
        end
        wr_reg(`TMR_OFS_CTRL, 8'h00);
        chk_rd(`TMR_OFS_CNT_LO, 8'h03, "pin edges");
        $display("test counter done");
        wr_reg(`TMR_OFS_RLD_LO, 8'h10);
        wr_reg(`TMR_OFS_RLD_HI, 8'h00);
        wr_reg(`TMR_OFS_CNT_LO, 8'h55);
        wr_reg(`TMR_OFS_CTRL, 8'h08);
        pin_fall();
        chk_rd(`TMR_OFS_CNT_LO, 8'h10, "ext reload");
        chk_rd(`TMR_OFS_CTRL, 8'h48, "ext flag");
        chk_rd(`TMR_OFS_IRQ_STAT, 8'h02, "ext irq");
        wr_reg(`TMR_OFS_CTRL, 8'h09);
        wr_reg(`TMR_OFS_CNT_LO, 8'h77);
        pin_fall();
        chk_rd(`TMR_OFS_RLD_LO, 8'h77, "capture");
        $display("test external done");
        wr_reg(`TMR_OFS_RLD_LO, 8'h10);
        wr_reg(`TMR_OFS_IRQ_STAT, 8'hFF);
        wr_reg(`TMR_OFS_CTRL, 8'h00);
        wr_reg(`TMR_OFS_MODE, 8'h01);
        wr_reg(`TMR_OFS_CNT_LO, 8'h11);
        wr_reg(`TMR_OFS_CTRL, 8'h04);
        repeat (28) @(posedge clock);
        chk_rd(`TMR_OFS_CTRL, 8'hC4, "underflow");
        wr_reg(`TMR_OFS_CTRL, 8'h00);
        chk_rd(`TMR_OFS_CNT_HI, 8'hFF, "load max");
        chk_rd(`TMR_OFS_IRQ_STAT, 8'h01, "no ext irq");
        @(posedge clock);
        dir_up <= 1'b1;
        repeat (3) @(posedge clock);
        wr_reg(`TMR_OFS_CTRL, 8'h04);
        repeat (40) @(posedge clock);
        chk_rd(`TMR_OFS_CTRL, 8'hC4, "up overflow");
        wr_reg(`TMR_OFS_CTRL, 8'h00);
        chk_rd(`TMR_OFS_CNT_HI, 8'h00, "up reload");
        $display("test up/down done");
        // Transmit clock select: capture select ignored, reload forced, no flag
        wr_reg(`TMR_OFS_IRQ_STAT, 8'hFF);
        wr_reg(`TMR_OFS_RLD_LO, 8'hFE);
        wr_reg(`TMR_OFS_RLD_HI, 8'hFF);
        wr_reg(`TMR_OFS_CNT_LO, 8'hFE);
        wr_reg(`TMR_OFS_CNT_HI, 8'hFF);
        wr_reg(`TMR_OFS_CTRL, 8'h15);
        repeat (44) @(posedge clock);
        chk_rd(`TMR_OFS_CTRL, 8'h15, "no flag serial");
        wr_reg(`TMR_OFS_CTRL, 8'h11);
        chk_rd(`TMR_OFS_CNT_LO, 8'hFE, "serial reload");
        chk_rd(`TMR_OFS_IRQ_STAT, 8'h00, "no serial irq");
        check(tx_ticks, 8'h02, "tx ticks");
        check(rx_ticks, 8'h00, "rx ticks");
        $display("test serial done");
        report_and_stop();
    end
endmodule // test_tmr2_timer
`default_nettype wire
